// ### core/scg_pkg.sv
// shared constants for the sleep-mode clock gating control block
package scg_pkg;

    // register byte offsets on the apb port
    localparam logic [11:0] SCG_SLEEP_GATE_OFFSET = 12'h110;
    localparam logic [11:0] SCG_IRQ_STATUS_OFFSET = 12'h180;
    localparam logic [11:0] SCG_IRQ_CLEAR_OFFSET = 12'h184;
    localparam logic [11:0] SCG_IRQ_ENABLE_OFFSET = 12'h188;

    // field positions inside sleep_clock_gate_ctrl0
    localparam int SCG_ADC_GATE_BIT = 16;
    localparam int SCG_RATE_LSB = 8;
    localparam int SCG_RATE_MSB = 9;
    localparam int SCG_FIXED_ONE_BIT = 6;
    localparam int SCG_WDT_GATE_BIT = 3;

    // reset values
    localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
    localparam logic SCG_ADC_GATE_RESET = 1'b0;
    localparam logic SCG_WDT_GATE_RESET = 1'b0;
    localparam logic [1:0] SCG_RATE_RESET = 2'h0;
    localparam logic [1:0] SCG_IRQ_RESET = 2'h0;

    // converter sample rate encodings
    localparam logic [1:0] SCG_RATE_125K = 2'h0;
    localparam logic [1:0] SCG_RATE_250K = 2'h1;

    // interrupt status layout: one bit per fault source
    localparam int SCG_IRQ_ADC_BIT = 0;
    localparam int SCG_IRQ_WDT_BIT = 1;
    localparam int SCG_IRQ_WIDTH = 2;

    // apb transfer phase of the slave, for reads and writes
    typedef enum {
        SCG_BUS_IDLE,
        SCG_BUS_ACCESS
    } scg_bus_state_t;

endpackage

// ### core/scg_unit_gate.sv
// clock enable and bus fault generation for one gated peripheral unit
`timescale 1ns/1ps
module scg_unit_gate
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sleepGate,     // gate bit from the sleep register
    input wire logic runGate,       // gate bit from the run-mode counterpart
    input wire logic useSleep,      // sleep register currently governs
    input wire logic unitAccess,    // bus access aimed at the unit
    output logic clockEnable,       // registered clock enable of the unit
    output logic busFault           // one-cycle fault pulse
);

    logic next_clockEnable; // selected gate setting

    // pick which register governs this unit
    always_comb begin
        if (useSleep) begin
            next_clockEnable = sleepGate;  // R9
        end else begin
            next_clockEnable = runGate;    // R10
        end
    end

    // registered enable, low from reset so the unit starts unclocked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clockEnable <= 1'b0;
        end else begin
            clockEnable <= next_clockEnable;  // R1
        end
    end

    // an access to an unclocked unit ends in a fault
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busFault <= 1'b0;
        end else begin
            busFault <= unitAccess && !clockEnable;  // R2
        end
    end

endmodule

// ### core/scg_clock_gate_ctrl.sv
// sleep-mode clock gating control register with apb slave and fault interrupt
//
// Summary of operation
// R1 - gate bit one clocks unit, zero stops
// R2 - access to gated unit gives bus fault
// R3 - reset clears gates, register reads 0x40
// R4 - software enables needed unit clocks first
// R5 - bit 16 gates converter module clock
// R6 - bit 3 gates watchdog unit clock
// R7 - bits 9:8 select converter sample rate
// R8 - software keeps rate within device maximum
// R9 - register governs only during sleep operation
// R10 - sleep settings need auto gating select
// R11 - software preserves reserved bits on update
// R12 - reserved bits ignore writes, fixed readback
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module scg_clock_gate_ctrl
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    // apb slave port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system mode and run-mode counterpart settings
    input wire logic sleepActive,
    input wire logic autoGatingSelect,
    input wire logic runGateAdc,
    input wire logic runGateWdt,
    input wire logic [1:0] runSampleRate,
    // access strobes from the interconnect toward the units
    input wire logic adcAccess,
    input wire logic wdtAccess,
    // unit clock enables, converter rate select and fault answers
    output logic adcClockEnable,
    output logic wdtClockEnable,
    output logic [1:0] converterSampleRateSel,
    output logic adcBusFault,
    output logic wdtBusFault,
    // interrupt
    output logic irq
);

    // sleep register storage, only the writable fields
    logic sleepGateAdc;           // converter gate bit
    logic sleepGateWdt;           // watchdog gate bit
    logic [1:0] sleepRate;        // converter sample rate field
    // interrupt registers
    logic [SCG_IRQ_WIDTH-1:0] irqStatus;  // sticky fault flags
    logic [SCG_IRQ_WIDTH-1:0] irqEnable;  // mask onto irq
    // bus decode
    scg_bus_state_t busState;     // tracks setup versus access
    logic setupPhase;             // first cycle of a transfer
    logic writeStrobe;            // write takes effect this edge
    logic hitGate;                // address is the sleep register
    logic hitStatus;              // address is the status register
    logic hitClear;               // address is the clear register
    logic hitEnable;              // address is the enable register
    logic mapped;                 // any known address
    logic useSleep;               // sleep register governs the units
    logic [31:0] gateWord;        // assembled sleep register value
    logic [31:0] gateWrite;       // byte-merged write data for the gate
    logic [31:0] enableWrite;     // byte-merged write data for enable
    logic [SCG_IRQ_WIDTH-1:0] clearMask;   // bits cleared this edge
    logic [SCG_IRQ_WIDTH-1:0] faultEvents; // fault pulses this cycle
    logic [1:0] next_sampleRate;  // selected rate setting

    // merge write data into old value under the byte strobes
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldValue,
        input logic [31:0] newValue,
        input logic [3:0] strobes
    );
        logic [31:0] result;
        result = oldValue;
        for (int i = 0; i < 4; i++) begin
            if (strobes[i]) begin
                result[i*8 +: 8] = newValue[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // build the gate register image; reserved bits are fixed
    function automatic logic [31:0] packGate(
        input logic adcBit,
        input logic [1:0] rate,
        input logic wdtBit
    );
        logic [31:0] word;
        word = SCG_GATE_RESET;                       // R12
        word[SCG_ADC_GATE_BIT] = adcBit;
        word[SCG_RATE_MSB:SCG_RATE_LSB] = rate;
        word[SCG_WDT_GATE_BIT] = wdtBit;
        return word;
    endfunction

    // extend the interrupt field into a bus word
    function automatic logic [31:0] packIrq(
        input logic [SCG_IRQ_WIDTH-1:0] flags
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        word[SCG_IRQ_WIDTH-1:0] = flags;
        return word;
    endfunction

    // address decode
    always_comb begin
        hitGate = (paddr == SCG_SLEEP_GATE_OFFSET);
        hitStatus = (paddr == SCG_IRQ_STATUS_OFFSET);
        hitClear = (paddr == SCG_IRQ_CLEAR_OFFSET);
        hitEnable = (paddr == SCG_IRQ_ENABLE_OFFSET);
        mapped = hitGate || hitStatus || hitClear || hitEnable;
    end

    // transfer phases; slave answers with no wait states
    assign setupPhase = psel && !penable;
    assign writeStrobe = psel && penable && pwrite && pready;
    assign pready = 1'b1;

    // bus phase tracker, used by the coverage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busState <= SCG_BUS_IDLE;
        end else begin
            case (busState)
                SCG_BUS_IDLE: begin
                    if (setupPhase) begin
                        busState <= SCG_BUS_ACCESS;
                    end
                end
                SCG_BUS_ACCESS: begin
                    if (setupPhase) begin
                        busState <= SCG_BUS_ACCESS;  // back-to-back setup
                    end else begin
                        busState <= SCG_BUS_IDLE;
                    end
                end
                default: begin
                    busState <= SCG_BUS_IDLE;
                end
            endcase
        end
    end

    // current register image and merged write values
    always_comb begin
        gateWord = packGate(sleepGateAdc, sleepRate, sleepGateWdt);
        gateWrite = mergeBytes(gateWord, pwdata, pstrb);
        enableWrite = mergeBytes(packIrq(irqEnable), pwdata, pstrb);
    end

    // writable fields of the sleep register; reserved bits dropped
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sleepGateAdc <= SCG_ADC_GATE_RESET;  // R3
            sleepGateWdt <= SCG_WDT_GATE_RESET;  // R3
            sleepRate <= SCG_RATE_RESET;         // R3
        end else if (writeStrobe && hitGate) begin
            sleepGateAdc <= gateWrite[SCG_ADC_GATE_BIT];           // R5
            sleepGateWdt <= gateWrite[SCG_WDT_GATE_BIT];           // R6
            sleepRate <= gateWrite[SCG_RATE_MSB:SCG_RATE_LSB];     // R7
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !mapped;  // unmapped address answers with error
            if (pwrite || !mapped) begin
                prdata <= 32'h0000_0000;
            end else if (hitGate) begin
                prdata <= gateWord;  // R12
            end else if (hitStatus) begin
                prdata <= packIrq(irqStatus);
            end else if (hitEnable) begin
                prdata <= packIrq(irqEnable);
            end else begin
                prdata <= 32'h0000_0000;  // clear register reads zero
            end
        end
    end

    // sleep settings apply only in sleep with auto gating selected
    assign useSleep = sleepActive && autoGatingSelect;  // R10

    // converter clock gate
    scg_unit_gate adcGate (
        .mclk(mclk),
        .resetn(resetn),
        .sleepGate(sleepGateAdc),
        .runGate(runGateAdc),
        .useSleep(useSleep),
        .unitAccess(adcAccess),
        .clockEnable(adcClockEnable),
        .busFault(adcBusFault)
    );

    // watchdog clock gate
    scg_unit_gate wdtGate (
        .mclk(mclk),
        .resetn(resetn),
        .sleepGate(sleepGateWdt),
        .runGate(runGateWdt),
        .useSleep(useSleep),
        .unitAccess(wdtAccess),
        .clockEnable(wdtClockEnable),
        .busFault(wdtBusFault)
    );

    // rate seen by the converter follows the governing register
    always_comb begin
        if (useSleep) begin
            next_sampleRate = sleepRate;      // R9
        end else begin
            next_sampleRate = runSampleRate;  // R10
        end
    end

    // registered sample rate select
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            converterSampleRateSel <= SCG_RATE_125K;
        end else begin
            converterSampleRateSel <= next_sampleRate;  // R7
        end
    end

    // fault events and write-one-to-clear mask
    always_comb begin
        faultEvents = '0;
        faultEvents[SCG_IRQ_ADC_BIT] = adcBusFault;
        faultEvents[SCG_IRQ_WDT_BIT] = wdtBusFault;
        clearMask = '0;
        if (writeStrobe && hitClear && pstrb[0]) begin
            clearMask = pwdata[SCG_IRQ_WIDTH-1:0];
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqStatus <= SCG_IRQ_RESET;
        end else begin
            irqStatus <= (irqStatus & ~clearMask) | faultEvents;
        end
    end

    // interrupt enable register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqEnable <= SCG_IRQ_RESET;
        end else if (writeStrobe && hitEnable) begin
            irqEnable <= enableWrite[SCG_IRQ_WIDTH-1:0];
        end
    end

    // level interrupt while any enabled flag is set
    assign irq = |(irqStatus & irqEnable);

    // checks on the block's own outputs and register state
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // register image right after reset
    AST_RESET_VALUE: assert property ($rose(resetn) |-> gateWord == SCG_GATE_RESET) // R3
        else $error("gate register not at reset value after reset");

    // converter enable follows sleep bit when sleep governs
    AST_ADC_SLEEP_GATE: assert property ( // R5
        useSleep |=> adcClockEnable == $past(sleepGateAdc))
        else $error("converter clock enable does not follow sleep bit");

    // watchdog enable follows sleep bit when sleep governs
    AST_WDT_SLEEP_GATE: assert property ( // R6
        useSleep |=> wdtClockEnable == $past(sleepGateWdt))
        else $error("watchdog clock enable does not follow sleep bit");

    // without auto gating the run settings rule
    AST_RUN_GOVERNS: assert property ( // R10
        !autoGatingSelect |=> adcClockEnable == $past(runGateAdc)
            && wdtClockEnable == $past(runGateWdt))
        else $error("run settings not applied without auto gating");

    // outside sleep the rate follows the run field
    AST_RATE_OUTSIDE_SLEEP: assert property ( // R9
        !sleepActive |=> converterSampleRateSel == $past(runSampleRate))
        else $error("sample rate not from run settings outside sleep");

    // access to an unclocked unit faults next cycle
    AST_FAULT_WHEN_GATED: assert property ( // R2
        adcAccess && !adcClockEnable |=> adcBusFault)
        else $error("no fault on access to gated converter");

    // access to a clocked unit never faults
    AST_NO_FAULT_CLOCKED: assert property ( // R1
        wdtAccess && wdtClockEnable |=> !wdtBusFault)
        else $error("fault on access to clocked watchdog");

    // rate field takes the written value
    AST_RATE_WRITE: assert property ( // R7
        writeStrobe && hitGate && pstrb[1]
            |=> sleepRate == $past(pwdata[SCG_RATE_MSB:SCG_RATE_LSB]))
        else $error("sample rate field did not take write data");

    // reserved bits read back fixed whatever was written
    AST_RESERVED_FIXED: assert property ( // R12
        writeStrobe && hitGate ##[1:4] setupPhase && !pwrite && hitGate
            |=> (prdata & ~32'h0001_0308) == SCG_GATE_RESET)
        else $error("reserved bits of gate register changed");

    // enabled fault raises irq and the flag stays sticky
    AST_IRQ_STICKY: assert property ( // R2
        adcBusFault && irqEnable[SCG_IRQ_ADC_BIT] |=> irq [*2]
            or (writeStrobe && hitClear))
        else $error("enabled fault did not hold interrupt");

    // main scenarios
    COV_GATE_WRITE: cover property (writeStrobe && hitGate ##1 useSleep ##1 adcClockEnable);
    COV_FAULT_IRQ: cover property (adcBusFault ##1 irq);
    COV_SET_AND_CLEAR: cover property (adcBusFault && |clearMask);
    COV_BACK_TO_BACK: cover property (busState == SCG_BUS_ACCESS && setupPhase);

endmodule

// ### dv/tb_top.sv
// self-checking bench for the sleep-mode clock gating control block
`timescale 1ns/1ps
module tb_top
    import scg_pkg::*;
;
    logic mclk = 1'b0; // system clock
    logic resetn = 1'b0; // async reset, active low
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb enable
    logic pwrite = 1'b0; // apb direction
    logic [11:0] paddr = 12'h000; // apb byte address
    logic [31:0] pwdata = 32'h0000_0000; // apb write data
    logic [3:0] pstrb = 4'hf; // apb byte strobes
    logic [31:0] prdata; // apb read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic sleepActive = 1'b0; // system in sleep
    logic autoGatingSelect = 1'b0; // auto gating select bit
    logic runGateAdc = 1'b0; // run-mode converter gate
    logic runGateWdt = 1'b0; // run-mode watchdog gate
    logic [1:0] runSampleRate = 2'h0; // run-mode rate field
    logic adcAccess = 1'b0; // access toward converter
    logic wdtAccess = 1'b0; // access toward watchdog
    logic adcClockEnable; // converter clock enable
    logic wdtClockEnable; // watchdog clock enable
    logic [1:0] converterSampleRateSel; // selected rate
    logic adcBusFault; // converter fault pulse
    logic wdtBusFault; // watchdog fault pulse
    logic irq; // interrupt level
    int nMismatch = 0; // mismatches seen
    int compares = 0; // comparisons made
    int cycles = 0; // timeout counter
    logic [31:0] rd; // last read data
    logic err; // last error flag

    scg_clock_gate_ctrl scg_clock_gate_ctrl_i (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepActive(sleepActive),
        .autoGatingSelect(autoGatingSelect), .runGateAdc(runGateAdc), .runGateWdt(runGateWdt),
        .runSampleRate(runSampleRate), .adcAccess(adcAccess), .wdtAccess(wdtAccess),
        .adcClockEnable(adcClockEnable), .wdtClockEnable(wdtClockEnable),
        .converterSampleRateSel(converterSampleRateSel), .adcBusFault(adcBusFault),
        .wdtBusFault(wdtBusFault), .irq(irq));

    // free-running clock, 20 ns period
    always #10 mclk = ~mclk;

    // hang guard: a few thousand cycles cover the whole run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nMismatch = nMismatch + 1;
            summarize();
        end
    end

    // verdict and end of run
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            nMismatch++;
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        // request stands until the edge that samples pready high
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        // answer taken at that same edge, before the slave's flops move
        rd = prdata;
        err = pslverr;
        // slave promises a one-cycle access phase
        chk("apb wait states", 32'h0, n - 1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // read and compare data and error flag
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("prdata", exp, rd);
        chk("pslverr", {31'h0, expErr}, {31'h0, err});
    endtask

    // unit clock enables, rate and irq, looked at mid-cycle
    task automatic outs(input logic ea, input logic ew, input logic [1:0] er, input logic ei);
        @(negedge mclk);
        chk("adcClockEnable", {31'h0, ea}, {31'h0, adcClockEnable});
        chk("wdtClockEnable", {31'h0, ew}, {31'h0, wdtClockEnable});
        chk("converterSampleRateSel", {30'h0, er}, {30'h0, converterSampleRateSel});
        chk("irq", {31'h0, ei}, {31'h0, irq});
        @(posedge mclk);
    endtask

    // one access cycle toward the units, fault pulse checked next cycle
    task automatic hit(input logic a, input logic w, input logic fa, input logic fw);
        adcAccess <= a;
        wdtAccess <= w;
        @(posedge mclk);
        adcAccess <= 1'b0;
        wdtAccess <= 1'b0;
        @(negedge mclk);
        chk("adcBusFault", {31'h0, fa}, {31'h0, adcBusFault});
        chk("wdtBusFault", {31'h0, fw}, {31'h0, wdtBusFault});
        @(posedge mclk);
    endtask

    // mode inputs, then let the registered outputs follow
    task automatic mode(input logic s, input logic g);
        sleepActive <= s;
        autoGatingSelect <= g;
        repeat (3) @(posedge mclk);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        // reset values and fixed bit
        outs(1'b0, 1'b0, 2'h0, 1'b0);
        rchk(SCG_SLEEP_GATE_OFFSET, SCG_GATE_RESET, 1'b0);
        rchk(SCG_IRQ_STATUS_OFFSET, 32'h0, 1'b0);
        rchk(SCG_IRQ_ENABLE_OFFSET, 32'h0, 1'b0);
        $display("test reset done");
        // writable fields only, reserved bits fixed
        apb(1'b1, SCG_SLEEP_GATE_OFFSET, 32'hffff_fdff, 4'hf);
        rchk(SCG_SLEEP_GATE_OFFSET, 32'h0001_0148, 1'b0);
        apb(1'b1, SCG_SLEEP_GATE_OFFSET, 32'h0000_0000, 4'hf);
        rchk(SCG_SLEEP_GATE_OFFSET, 32'h0000_0040, 1'b0);
        apb(1'b1, SCG_SLEEP_GATE_OFFSET, 32'h0001_0108, 4'h2);
        rchk(SCG_SLEEP_GATE_OFFSET, 32'h0000_0140, 1'b0);
        apb(1'b1, SCG_SLEEP_GATE_OFFSET, 32'h0001_0140, 4'hf);
        $display("test register done");
        // sleep settings apply only with sleep and auto gating both set
        runGateWdt <= 1'b1;
        mode(1'b0, 1'b0);
        outs(1'b0, 1'b1, SCG_RATE_125K, 1'b0);
        mode(1'b1, 1'b0);
        outs(1'b0, 1'b1, SCG_RATE_125K, 1'b0);
        mode(1'b0, 1'b1);
        outs(1'b0, 1'b1, SCG_RATE_125K, 1'b0);
        mode(1'b1, 1'b1);
        outs(1'b1, 1'b0, SCG_RATE_250K, 1'b0);
        $display("test mode select done");
        // faults only toward unclocked units, two accesses an idle cycle apart
        hit(1'b1, 1'b1, 1'b0, 1'b1);
        hit(1'b0, 1'b1, 1'b0, 1'b1);
        rchk(SCG_IRQ_STATUS_OFFSET, 32'h2, 1'b0);
        outs(1'b1, 1'b0, SCG_RATE_250K, 1'b0);
        apb(1'b1, SCG_IRQ_ENABLE_OFFSET, 32'h3, 4'hf);
        outs(1'b1, 1'b0, SCG_RATE_250K, 1'b1);
        apb(1'b1, SCG_IRQ_STATUS_OFFSET, 32'h0, 4'hf);
        rchk(SCG_IRQ_STATUS_OFFSET, 32'h2, 1'b0);
        apb(1'b1, SCG_IRQ_CLEAR_OFFSET, 32'h2, 4'hf);
        rchk(SCG_IRQ_CLEAR_OFFSET, 32'h0, 1'b0);
        rchk(SCG_IRQ_STATUS_OFFSET, 32'h0, 1'b0);
        outs(1'b1, 1'b0, SCG_RATE_250K, 1'b0);
        // ungate watchdog, gate converter
        apb(1'b1, SCG_SLEEP_GATE_OFFSET, 32'h0000_0048, 4'hf);
        repeat (2) @(posedge mclk);
        outs(1'b0, 1'b1, SCG_RATE_125K, 1'b0);
        hit(1'b1, 1'b1, 1'b1, 1'b0);
        rchk(SCG_IRQ_STATUS_OFFSET, 32'h1, 1'b0);
        apb(1'b1, SCG_IRQ_ENABLE_OFFSET, 32'h2, 4'hf);
        outs(1'b0, 1'b1, SCG_RATE_125K, 1'b0);
        apb(1'b1, SCG_IRQ_CLEAR_OFFSET, 32'h1, 4'hf);
        $display("test faults and interrupt done");
        // unmapped addresses answer with error and change nothing
        rchk(12'h200, 32'h0, 1'b1);
        apb(1'b1, 12'h114, 32'h0001_0000, 4'hf);
        chk("pslverr", 32'h1, {31'h0, err});
        rchk(SCG_SLEEP_GATE_OFFSET, 32'h0000_0048, 1'b0);
        $display("test unmapped done");
        // reset in mid-run clears every gate
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        outs(1'b0, 1'b0, 2'h0, 1'b0);
        rchk(SCG_SLEEP_GATE_OFFSET, SCG_GATE_RESET, 1'b0);
        hit(1'b1, 1'b1, 1'b1, 1'b1);
        $display("test second reset done");
        summarize();
    end
endmodule
